// file: hdl/bmc_defs.svh
// Constants for the breakpoint-control register and its access port
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH

`define BMC_CTRL_W        64
`define BMC_HALF_W        32
`define BMC_CTRL_IDX      3'h7
`define BMC_ALIAS_IDX     3'h5
`define BMC_PRIV_LEVEL    2'h0

`define BMC_RESET_VAL     64'h0000_0000_0000_0400
`define BMC_WRITE_MASK    64'h0000_0000_FFFF_23FF
`define BMC_LOCAL_MASK    64'h0000_0000_0000_0055
`define BMC_ANY_TASK_MASK 64'h0000_0000_0000_00AA
`define BMC_RSVD0_MASK    64'hFFFF_FFFF_0000_D800
`define BMC_RSVD1_MASK    64'h0000_0000_0000_0400

`define BMC_TRAP_EN_BIT   13
`define BMC_EXACT_LOC_BIT 8
`define BMC_EXACT_ANY_BIT 9
`define BMC_EN_STRIDE     2
`define BMC_TYPE_LSB      16
`define BMC_LEN_LSB       18
`define BMC_FIELD_STRIDE  4

`define BMC_TYPE_EXEC     2'h0
`define BMC_TYPE_WRITE    2'h1
`define BMC_TYPE_IO       2'h2
`define BMC_TYPE_RDWR     2'h3

`define BMC_LEN_1         2'h0
`define BMC_LEN_2         2'h1
`define BMC_LEN_8         2'h2
`define BMC_LEN_4         2'h3

`define BMC_MASK_1        4'h0
`define BMC_MASK_2        4'h1
`define BMC_MASK_4        4'h3
`define BMC_MASK_8        4'h7

`endif

// file: hdl/bmc_pkg.sv
// Types shared by the breakpoint-control logic
package bmc_pkg;

   typedef enum logic [2:0]
   {
      bmc_acc_exec,
      bmc_acc_dread,
      bmc_acc_dwrite,
      bmc_acc_ioread,
      bmc_acc_iowrite
   } bmc_acc_kind_t;

endpackage : bmc_pkg

// file: hdl/bmc_match_unit.sv
// Address and access-type comparator for one address-match register
`timescale 1ns/1ps
`include "bmc_defs.svh"

module bmc_match_unit #(
   parameter int ADDR_W = 64
) (
   input  wire logic [ADDR_W-1:0]       base_i,
   input  wire logic [1:0]              type_i,
   input  wire logic [1:0]              len_i,
   input  wire logic                    io_break_ext_flag_i,
   input  wire logic                    long_mode_i,
   input  wire bmc_pkg::bmc_acc_kind_t  acc_kind_i,
   input  wire logic [ADDR_W-1:0]       acc_addr_i,
   input  wire logic [3:0]              acc_bytes_i,
   output logic                         hit_o
);

   logic [3:0]        low_mask;
   logic              len_ok;
   logic              kind_ok;
   logic [ADDR_W-1:0] range_lo;
   logic [ADDR_W-1:0] range_hi;
   logic [ADDR_W-1:0] acc_last;

   always_comb
   begin
      len_ok = 1'b1;
      case (len_i)
         `BMC_LEN_1: low_mask = `BMC_MASK_1;
         `BMC_LEN_2: low_mask = `BMC_MASK_2;
         `BMC_LEN_4: low_mask = `BMC_MASK_4;
         `BMC_LEN_8:
         begin
            low_mask = `BMC_MASK_8;
            // Undefined outside long mode; chosen never to match
            len_ok   = long_mode_i;
         end
         default:    low_mask = `BMC_MASK_1;
      endcase
   end

   always_comb
   begin
      case (type_i)
         `BMC_TYPE_EXEC:  kind_ok = (acc_kind_i == bmc_pkg::bmc_acc_exec);
         `BMC_TYPE_WRITE: kind_ok = (acc_kind_i == bmc_pkg::bmc_acc_dwrite);
         `BMC_TYPE_RDWR:  kind_ok = (acc_kind_i == bmc_pkg::bmc_acc_dread) ||
                                    (acc_kind_i == bmc_pkg::bmc_acc_dwrite);
         // I/O only with the extension flag
         `BMC_TYPE_IO:    kind_ok = io_break_ext_flag_i &&
                                    ((acc_kind_i == bmc_pkg::bmc_acc_ioread) ||
                                     (acc_kind_i == bmc_pkg::bmc_acc_iowrite));
         default:         kind_ok = 1'b0;
      endcase
   end

   // low bits masked out of base
   assign range_lo = base_i & ~ADDR_W'(low_mask);
   assign range_hi = base_i | ADDR_W'(low_mask);
   // Zero byte count treated as one byte
   assign acc_last = acc_addr_i + ADDR_W'(acc_bytes_i) - ADDR_W'(acc_bytes_i != 4'h0);

   assign hit_o = kind_ok && len_ok && (acc_addr_i <= range_hi) && (acc_last >= range_lo);

endmodule : bmc_match_unit

// file: hdl/bmc_breakpoint_control.sv
// Breakpoint-control register, debug-register access checks and breakpoint detection
`timescale 1ns/1ps
`include "bmc_defs.svh"

// Overview of operation
// - Local enables allow exception in current task
// - Task switch clears all local enables
// - Any-task enables allow exception, never cleared
// - Old exact bits stored, otherwise ignored
// - Breakpoints reported exactly at trigger
// - Trap enable traps every debug-register move made at privilege level 0
// - Handler entry clears trap enable
// - Trap precedes move and sets flag
// - Access-type fields at fixed bit pairs
// - Type 00 exec, 01 write, 11 rd/wr
// - Type 10 is I/O with extension flag
// - Length fields at fixed bit pairs
// - Length masks low base bits
// - Lengths 1, 2, 4 bytes, 8 long-mode
// - Reserved bits fixed zero, bit 10 one
// - Upper half written nonzero faults in long-mode
// - Defined fields read back last write
// - Access-trap flag is status bit 13
// - Any accessed byte in range matches
// - Less privileged access faults
module bmc_breakpoint_control #(
   parameter int NUM_BP = 4,
   parameter int ADDR_W = 64
) (
   input  wire logic                             core_clk_i,
   input  wire logic                             arst_n_i,
   input  wire logic                             dr_req_i,
   input  wire logic                             dr_write_i,
   input  wire logic [2:0]                       dr_index_i,
   input  wire logic [`BMC_CTRL_W-1:0]           dr_wdata_i,
   input  wire logic [1:0]                       cpl_i,
   input  wire logic                             long_mode_i,
   input  wire logic                             io_break_ext_flag_i,
   input  wire logic                             task_switch_i,
   input  wire logic                             db_handler_entry_i,
   input  wire logic                             access_trap_clear_i,
   input  wire logic [NUM_BP-1:0][ADDR_W-1:0]    address_match_regs_i,
   input  wire logic                             acc_valid_i,
   input  wire bmc_pkg::bmc_acc_kind_t           acc_kind_i,
   input  wire logic [ADDR_W-1:0]                acc_addr_i,
   input  wire logic [3:0]                       acc_bytes_i,
   output logic                                  dr_ack_o,
   output logic [`BMC_CTRL_W-1:0]                dr_rdata_o,
   output logic                                  general_protection_fault_o,
   output logic                                  debug_exception_o,
   output logic                                  access_trap_flag_o,
   output logic [NUM_BP-1:0]                     match_status_o
);

   function automatic logic [1:0] type_of(input logic [`BMC_CTRL_W-1:0] c, input int n);
      return c[`BMC_TYPE_LSB + n * `BMC_FIELD_STRIDE +: 2];
   endfunction : type_of

   function automatic logic [1:0] len_of(input logic [`BMC_CTRL_W-1:0] c, input int n);
      return c[`BMC_LEN_LSB + n * `BMC_FIELD_STRIDE +: 2];
   endfunction : len_of

   // reserved bits forced on every store
   function automatic logic [`BMC_CTRL_W-1:0] sanitize(input logic [`BMC_CTRL_W-1:0] w);
      return (w & `BMC_WRITE_MASK) | `BMC_RESET_VAL;
   endfunction : sanitize

   logic [`BMC_CTRL_W-1:0] breakpoint_control;
   logic [`BMC_CTRL_W-1:0] next_breakpoint_control;
   logic                   next_dr_ack;
   logic [`BMC_CTRL_W-1:0] next_dr_rdata;
   logic                   next_gp_fault;
   logic                   next_debug_exception;
   logic                   next_access_trap_flag;
   logic [NUM_BP-1:0]      next_match_status;

   logic [NUM_BP-1:0]      raw_hit;
   logic [NUM_BP-1:0]      enabled_hit;
   logic                   ctrl_sel;
   logic                   priv_fail;
   logic                   trap_move;
   logic                   upper_fault;
   logic                   wr_ok;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_BP; gi++)
      begin : g_bp
         bmc_match_unit #(
            .ADDR_W (ADDR_W)
         ) u_match (
            .base_i              (address_match_regs_i[gi]),
            .type_i              (type_of(breakpoint_control, gi)),
            .len_i               (len_of(breakpoint_control, gi)),
            .io_break_ext_flag_i (io_break_ext_flag_i),
            .long_mode_i         (long_mode_i),
            .acc_kind_i          (acc_kind_i),
            .acc_addr_i          (acc_addr_i),
            .acc_bytes_i         (acc_bytes_i),
            .hit_o               (raw_hit[gi])
         );
         assign enabled_hit[gi] = raw_hit[gi] &&
                                  (breakpoint_control[gi * `BMC_EN_STRIDE] ||
                                   breakpoint_control[gi * `BMC_EN_STRIDE + 1]);
      end
   endgenerate

   // Alias index reaches this register only while the extension flag is clear
   assign ctrl_sel    = (dr_index_i == `BMC_CTRL_IDX) ||
                        ((dr_index_i == `BMC_ALIAS_IDX) && !io_break_ext_flag_i);
   assign priv_fail   = dr_req_i && (cpl_i != `BMC_PRIV_LEVEL);
   // any of the eight indices traps
   assign trap_move   = dr_req_i && !priv_fail && breakpoint_control[`BMC_TRAP_EN_BIT];
   // nonzero upper half in long mode
   assign upper_fault = dr_req_i && !priv_fail && !trap_move && dr_write_i && ctrl_sel &&
                        long_mode_i && (|dr_wdata_i[`BMC_CTRL_W-1:`BMC_HALF_W]);
   assign wr_ok       = dr_req_i && !priv_fail && !trap_move && dr_write_i && ctrl_sel &&
                        !upper_fault;

   always_comb
   begin
      next_breakpoint_control = breakpoint_control;
      next_dr_ack             = dr_req_i;
      next_dr_rdata           = '0;
      next_gp_fault           = priv_fail || upper_fault;
      next_debug_exception    = 1'b0;
      next_access_trap_flag   = access_trap_flag_o;
      next_match_status       = match_status_o;

      if (access_trap_clear_i)
      begin
         next_access_trap_flag = 1'b0;
      end

      // trap taken, the move is not performed
      if (trap_move)
      begin
         next_debug_exception  = 1'b1;
         // status bit set, wins over a clear
         next_access_trap_flag = 1'b1;
         next_match_status     = '0;
      end

      if (wr_ok)
      begin
         next_breakpoint_control = sanitize({{`BMC_HALF_W{1'b0}}, dr_wdata_i[`BMC_HALF_W-1:0]});
      end

      // Upper half always reads zero, so one path serves both modes
      if (dr_req_i && !priv_fail && !trap_move && !dr_write_i && ctrl_sel)
      begin
         next_dr_rdata = breakpoint_control;
      end

      // reported the cycle after the access, never deferred
      if (acc_valid_i && (|enabled_hit))
      begin
         next_debug_exception = 1'b1;
         next_match_status    = enabled_hit;
      end

      // hardware clears win over a same-cycle write
      if (task_switch_i)
      begin
         next_breakpoint_control = next_breakpoint_control & ~`BMC_LOCAL_MASK;
      end

      // handler may then touch debug registers
      if (db_handler_entry_i)
      begin
         next_breakpoint_control[`BMC_TRAP_EN_BIT] = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         breakpoint_control         <= `BMC_RESET_VAL;
         dr_ack_o                   <= 1'b0;
         dr_rdata_o                 <= '0;
         general_protection_fault_o <= 1'b0;
         debug_exception_o          <= 1'b0;
         access_trap_flag_o         <= 1'b0;
         match_status_o             <= '0;
      end
      else
      begin
         breakpoint_control         <= next_breakpoint_control;
         dr_ack_o                   <= next_dr_ack;
         dr_rdata_o                 <= next_dr_rdata;
         general_protection_fault_o <= next_gp_fault;
         debug_exception_o          <= next_debug_exception;
         access_trap_flag_o         <= next_access_trap_flag;
         match_status_o             <= next_match_status;
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   chk_priv_fault: assert property (dr_req_i && (cpl_i != `BMC_PRIV_LEVEL) && !(acc_valid_i && (|enabled_hit))
      |=> dr_ack_o && general_protection_fault_o && !debug_exception_o)
      else $error("less privileged move did not fault");

   chk_trap_raise: assert property (dr_req_i && (cpl_i == `BMC_PRIV_LEVEL) &&
      breakpoint_control[`BMC_TRAP_EN_BIT]
      |=> debug_exception_o && access_trap_flag_o && !general_protection_fault_o)
      else $error("trapped move raised no debug exception");

   chk_trap_no_write: assert property (trap_move && dr_write_i && !task_switch_i && !db_handler_entry_i
      |=> breakpoint_control == $past(breakpoint_control))
      else $error("trapped move changed the register");

   chk_local_clear: assert property (task_switch_i
      |=> (breakpoint_control & `BMC_LOCAL_MASK) == '0)
      else $error("task switch left a local enable set");

   chk_trap_en_clear: assert property (db_handler_entry_i
      |=> !breakpoint_control[`BMC_TRAP_EN_BIT] ##1 !debug_exception_o || !$past(trap_move))
      else $error("handler entry kept the trap enable");

   // any-task enables only change by write
   chk_any_task_kept: assert property (!wr_ok
      |=> (breakpoint_control & `BMC_ANY_TASK_MASK) == ($past(breakpoint_control) & `BMC_ANY_TASK_MASK))
      else $error("any-task enable changed without a write");

   chk_upper_fault: assert property (upper_fault && !task_switch_i && !db_handler_entry_i
      |=> general_protection_fault_o && (breakpoint_control == $past(breakpoint_control)))
      else $error("nonzero upper half not refused");

   chk_reserved_bits: assert property ((breakpoint_control & `BMC_RSVD0_MASK) == '0 &&
      (breakpoint_control & `BMC_RSVD1_MASK) == `BMC_RSVD1_MASK)
      else $error("reserved bit has wrong value");

   chk_write_back: assert property (wr_ok && !task_switch_i && !db_handler_entry_i
      |=> breakpoint_control ==
          sanitize({{`BMC_HALF_W{1'b0}}, $past(dr_wdata_i[`BMC_HALF_W-1:0])}))
      else $error("written value not stored");

   chk_hit_report: assert property (acc_valid_i && (|enabled_hit)
      |=> debug_exception_o && (match_status_o == $past(enabled_hit)))
      else $error("enabled breakpoint hit not reported");

   chk_no_enable: assert property (acc_valid_i && (enabled_hit == '0) && !trap_move
      |=> !debug_exception_o)
      else $error("exception without an enabled hit");

   chk_ack_answer: assert property (dr_req_i |=> dr_ack_o)
      else $error("move request not acknowledged");

   chk_idle_quiet: assert property (!dr_req_i
      |=> !dr_ack_o && (dr_rdata_o == '0) && !general_protection_fault_o)
      else $error("answer without a move request");

   chk_read_data: assert property (dr_req_i && !dr_write_i && !priv_fail && !trap_move && ctrl_sel
      |=> dr_rdata_o == $past(breakpoint_control))
      else $error("read data differs from register");

   chk_flag_sticky: assert property (access_trap_flag_o && !access_trap_clear_i
      |=> access_trap_flag_o)
      else $error("access-trap flag dropped without clear");

   chk_flag_clear: assert property (access_trap_flag_o && access_trap_clear_i && !trap_move
      |=> !access_trap_flag_o)
      else $error("access-trap flag not cleared");

   chk_io_needs_ext: assert property (!io_break_ext_flag_i &&
      (type_of(breakpoint_control, 0) == `BMC_TYPE_IO) |-> !raw_hit[0])
      else $error("I/O breakpoint matched without extension flag");

   chk_len8_long: assert property (!long_mode_i &&
      (len_of(breakpoint_control, 0) == `BMC_LEN_8) |-> !raw_hit[0])
      else $error("eight-byte range matched outside long mode");

endmodule : bmc_breakpoint_control

// file: verif/bmc_breakpoint_control_tb.sv
// Self-checking testbench for the breakpoint-control block
`timescale 1ns/1ps
`include "bmc_defs.svh"

module bmc_breakpoint_control_tb;
   logic                   clk = 1'b0;
   logic                   arst_n = 1'b0;
   logic                   req = 1'b0, wr = 1'b0, lm = 1'b0, ioe = 1'b0;
   logic                   ts = 1'b0, hent = 1'b0, tclr = 1'b0, av = 1'b0;
   logic [2:0]             idx = 3'h0;
   logic [1:0]             cpl = 2'h0;
   logic [63:0]            wdata = '0, aaddr = '0, ctrl;
   logic [3:0][63:0]       amr = '0;
   bmc_pkg::bmc_acc_kind_t akind = bmc_pkg::bmc_acc_exec;
   logic [3:0]             abytes = 4'h1, ms, mst;
   logic                   ack, gp, dbx, tflag, tf;
   logic [63:0]            rdata;
   logic [31:0]            seed = 32'h5ae5_5154;
   int                     fail_count = 0;
   int                     n_compared = 0;

   bmc_breakpoint_control i_bmc_breakpoint_control (.core_clk_i(clk), .arst_n_i(arst_n), .dr_req_i(req),
      .dr_write_i(wr), .dr_index_i(idx), .dr_wdata_i(wdata), .cpl_i(cpl), .long_mode_i(lm),
      .io_break_ext_flag_i(ioe), .task_switch_i(ts), .db_handler_entry_i(hent), .access_trap_clear_i(tclr),
      .address_match_regs_i(amr), .acc_valid_i(av), .acc_kind_i(akind), .acc_addr_i(aaddr),
      .acc_bytes_i(abytes), .dr_ack_o(ack), .dr_rdata_o(rdata), .general_protection_fault_o(gp),
      .debug_exception_o(dbx), .access_trap_flag_o(tflag), .match_status_o(mst));

   initial forever #12.5 clk = ~clk;

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic results();
      $display("compared=%0d mismatches=%0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
      return seed;
   endfunction : rnd

   // Expected hit of one address-match register
   function automatic logic bp_hit(input int n, input bmc_pkg::bmc_acc_kind_t k, input logic [63:0] a,
                                   input logic [3:0] b);
      logic [1:0]  ty, ln;
      logic [63:0] m, lo, hi, last;
      logic        km;
      ty = ctrl[16+4*n +: 2];
      ln = ctrl[18+4*n +: 2];
      m = (ln == 2'h1) ? 64'h1 : (ln == 2'h3) ? 64'h3 : (ln == 2'h2) ? 64'h7 : 64'h0;
      km = (ty == 2'h0) ? (k == bmc_pkg::bmc_acc_exec) : (ty == 2'h1) ? (k == bmc_pkg::bmc_acc_dwrite)
         : (ty == 2'h3) ? (k == bmc_pkg::bmc_acc_dread || k == bmc_pkg::bmc_acc_dwrite)
         : (ioe && (k == bmc_pkg::bmc_acc_ioread || k == bmc_pkg::bmc_acc_iowrite));
      if (ln == 2'h2 && !lm)
         km = 1'b0;
      lo = amr[n] & ~m;
      hi = amr[n] | m;
      last = a + ((b == 4'h0) ? 64'h0 : 64'(b) - 64'h1);
      return km && (ctrl[2*n] || ctrl[2*n+1]) && (a <= hi) && (last >= lo);
   endfunction : bp_hit

   // One register move with its expected answer
   task automatic dr_chk(input logic w, input logic [2:0] i, input logic [63:0] d);
      logic        hc, gpx, tr;
      logic [63:0] ed;
      hc = (i == 3'h7) || (i == 3'h5 && !ioe);
      tr = (cpl == 2'h0) && ctrl[13];
      gpx = (cpl != 2'h0) || (!tr && w && hc && lm && (d[63:32] != 32'h0));
      ed = (!w && hc && !gpx && !tr) ? ctrl : 64'h0;
      @(negedge clk);
      req = 1'b1;
      wr = w;
      idx = i;
      wdata = d;
      @(negedge clk);
      req = 1'b0;
      if (w && hc && !gpx && !tr)
         ctrl = (d & 64'h0000_0000_FFFF_23FF) | 64'h0000_0000_0000_0400;
      if (tr)
      begin
         tf = 1'b1;
         ms = 4'h0;
      end
      chk(ack, 1'b1);
      chk(gp, gpx);
      chk(dbx, tr);
      chk(rdata, ed);
      chk(tflag, tf);
      chk(mst, ms);
   endtask : dr_chk

   // Pulses: 0 task switch, 1 handler entry, 2 flag clear
   task automatic pulse(input int which);
      @(negedge clk);
      ts = (which == 0);
      hent = (which == 1);
      tclr = (which == 2);
      @(negedge clk);
      ts = 1'b0;
      hent = 1'b0;
      tclr = 1'b0;
      if (which == 0)
         ctrl = ctrl & ~64'h0000_0000_0000_0055;
      else if (which == 1)
         ctrl[13] = 1'b0;
      else
         tf = 1'b0;
   endtask : pulse

   task automatic acc(input bmc_pkg::bmc_acc_kind_t k, input logic [63:0] a, input logic [3:0] b);
      logic [3:0] h;
      for (int n = 0; n < 4; n++)
         h[n] = bp_hit(n, k, a, b);
      @(negedge clk);
      av = 1'b1;
      akind = k;
      aaddr = a;
      abytes = b;
      @(negedge clk);
      av = 1'b0;
      if (|h)
         ms = h;
      chk(dbx, |h);
      chk(mst, ms);
   endtask : acc

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end

   initial
   begin
      logic [31:0] r, r2;
      logic [63:0] d;
      ctrl = 64'h0000_0000_0000_0400;
      ms = 4'h0;
      tf = 1'b0;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      dr_chk(1'b0, 3'h7, 64'h0);
      dr_chk(1'b0, 3'h5, 64'h0);
      cpl = 2'h3;
      dr_chk(1'b1, 3'h7, 64'h0000_0000_0000_00FF);
      cpl = 2'h0;
      for (int i = 0; i < 40; i++)
      begin
         r = rnd();
         cpl = (r[3:0] == 4'h0) ? r[5:4] : 2'h0;
         lm = r[6];
         ioe = r[7];
         d = {rnd() & (r[13] ? 32'hFFFF_FFFF : 32'h0000_0000), rnd() & 32'hFFFF_DFFF};
         dr_chk(r[8], r[9] ? 3'h7 : r[12:10], d);
         cpl = 2'h0;
         dr_chk(1'b0, 3'h7, 64'h0);
      end
      lm = 1'b0;
      ioe = 1'b0;
      dr_chk(1'b1, 3'h7, 64'h0000_0000_FFFF_03FF);
      pulse(0);
      dr_chk(1'b0, 3'h7, 64'h0);
      dr_chk(1'b1, 3'h7, 64'h0000_0000_0000_2000);
      dr_chk(1'b0, 3'h2, 64'h0);
      dr_chk(1'b1, 3'h7, 64'h0000_0000_0000_0003);
      pulse(1);
      dr_chk(1'b0, 3'h7, 64'h0);
      pulse(2);
      chk(tflag, tf);
      // Table corner: one-byte range at F000, read/write type
      amr[0] = 64'h0000_0000_0000_F000;
      dr_chk(1'b1, 3'h7, 64'h0000_0000_0003_0002);
      acc(bmc_pkg::bmc_acc_dread, 64'h0000_0000_0000_EFFB, 4'h8);
      acc(bmc_pkg::bmc_acc_dwrite, 64'h0000_0000_0000_EFFE, 4'h2);
      for (int i = 0; i < 150; i++)
      begin
         r = rnd();
         r2 = rnd();
         d = {32'h0, rnd() & 32'hFFFF_03FF};
         for (int n = 0; n < 4; n++)
         begin
            if (d[16+4*n +: 2] == 2'h0)
               d[18+4*n +: 2] = 2'h0;
            amr[n] = 64'h0000_0000_0000_F000 + 64'(r2[4*n +: 4] & 4'h8);
         end
         lm = r[0];
         ioe = r[1];
         dr_chk(1'b1, 3'h7, d);
         for (int j = 0; j < 3; j++)
         begin
            r = rnd();
            acc(bmc_pkg::bmc_acc_kind_t'(r[15:13] % 3'h5), 64'h0000_0000_0000_EFFC + 64'(r[8:4]),
                {1'b0, r[11:9]} + 4'h1);
         end
         if (r[20])
            pulse(0);
      end
      results();
   end
endmodule : bmc_breakpoint_control_tb
